// *** rtl/dhm_attr.sv ***
// One monitored attribute: interval, failure and history counters.
`timescale 1ns/1ns
module dhm_attr
  import dhm_pkg::*;
#(
  parameter int unsigned CNT_W = 16 // Counter width
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n_sync, // Synchronised reset, active low
  input wire logic enable, // Collection enabled
  input wire logic op_evt, // One operation observed
  input wire logic err_evt, // One error observed
  input wire logic [CNT_W-1:0] interval_len, // Operations per interval
  input wire logic [CNT_W-1:0] err_thresh, // Errors allowed per interval
  input wire logic [CNT_W-1:0] pred_thresh, // History level that predicts
  output logic predict, // History reached threshold
  output logic [CNT_W-1:0] history // History counter value
);

  // ----------------------------------------------------------------------
  // Counter state
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] ival_reg, ival_next; // Interval counter
  logic [CNT_W-1:0] fail_reg, fail_next; // Failure counter
  logic [CNT_W-1:0] hist_reg, hist_next; // History counter
  logic [CNT_W-1:0] fail_inc; // Failures including this cycle
  logic ival_end; // Interval expires this cycle
  logic bad; // Interval judged unacceptable

  // Next-state: count ops and errors, judge at interval end
  always_comb begin
    ival_next = ival_reg;
    fail_next = fail_reg;
    hist_next = hist_reg;
    fail_inc = fail_reg + CNT_W'(err_evt);
    ival_end = 1'b0;
    bad = 1'b0;
    if (enable) begin
      ival_next = ival_reg + CNT_W'(op_evt);
      fail_next = fail_inc;
      bad = fail_inc > err_thresh;
      ival_end = bad || (op_evt && (ival_reg + 1'b1 >= interval_len));
      if (ival_end) begin
        // Both counters restart regardless of verdict
        ival_next = '0;
        fail_next = '0;
        if (bad) begin
          if (hist_reg != '1) begin
            hist_next = hist_reg + 1'b1;
          end
        end else if (hist_reg != '0) begin
          hist_next = hist_reg - 1'b1; // saturate at zero
        end
      end
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ival_reg <= '0;
      fail_reg <= '0;
      hist_reg <= '0;
    end else begin
      ival_reg <= ival_next;
      fail_reg <= fail_next;
      hist_reg <= hist_next;
    end
  end

  assign predict = (pred_thresh != '0) && (hist_reg >= pred_thresh);
  assign history = hist_reg;

endmodule

// *** rtl/dhm_pkg.sv ***
// Package of constants and types for the drive health monitor.
package dhm_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned DHM_CLK_HZ = 100_000_000; // System clock rate
  localparam int unsigned DHM_HOUR_S = 3600; // Schedule period in seconds
  localparam longint unsigned DHM_HOUR_CYC = 64'(DHM_HOUR_S) * 64'(DHM_CLK_HZ);
  localparam int unsigned DHM_DELAY_MS = 75; // Longest added command delay
  localparam int unsigned DHM_DELAY_CYC = DHM_DELAY_MS * (DHM_CLK_HZ / 1000);
  localparam int unsigned DHM_TMR_W = 40; // Width of the hour down-counter

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] DHM_IEC_PAGE = 8'h1C; // Control mode page
  localparam logic [7:0] DHM_LOG_PAGE = 8'h3E; // Remaining-time log page
  localparam logic [3:0] DHM_EXCEPTION_REPORT_METHOD_SENSE = 4'h1; // Report by sense code
  localparam logic [7:0] DHM_SENSE_KEY = 8'h01; // Recovered error key
  localparam logic [7:0] DHM_SENSE_ASC = 8'h5D; // Failure prediction code
  localparam logic [7:0] DHM_SENSE_ASCQ = 8'h00; // Qualifier

  // ----------------------------------------------------------------------
  // Off-line pass states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    DHM_IDLE = 3'b001, // Waiting for schedule or force
    DHM_MEAS = 3'b010, // Measuring off-line attributes
    DHM_SAVE = 3'b100 // Saving attribute data to the medium
  } dhm_state_t;

endpackage

// *** rtl/dhm_top.sv ***
// Drive health monitor top: scheduling, off-line passes and reporting.
`timescale 1ns/1ns
module dhm_top
  import dhm_pkg::*;
#(
  parameter int unsigned NATTR = 4, // Number of monitored attributes
  parameter int unsigned CNT_W = 16, // Attribute counter width
  parameter longint unsigned HOUR_CYC = DHM_HOUR_CYC, // Cycles per hour
  parameter int unsigned DELAY_CYC = DHM_DELAY_CYC, // Cycles of 75 ms
  parameter int unsigned MEAS_CYC = 64, // Cycles spent measuring
  parameter int unsigned SAVE_CYC = 64 // Cycles spent saving
) (
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic monitor_disable_bit, // Suspend all monitoring
  input wire logic online_only_bit, // No off-line passes
  input wire logic [3:0] exception_report_method, // Reporting method
  input wire logic host_busy, // Host interface activity
  input wire logic rezero_force_command, // Rezero pulse, forces a pass
  input wire logic log_sense_req, // Log sense request pulse
  input wire logic [7:0] log_sense_page, // Page of the log request
  input wire logic [NATTR-1:0] op_evt, // Operation per attribute
  input wire logic [NATTR-1:0] err_evt, // Error per attribute
  input wire logic [CNT_W-1:0] interval_len, // Interval length
  input wire logic [CNT_W-1:0] err_thresh, // Error threshold
  input wire logic [CNT_W-1:0] pred_thresh, // Predictive threshold
  input wire logic nv_valid, // Stored report present
  input wire logic [7:0] nv_unit, // Stored failing unit
  input wire logic sense_ack, // Host took the sense data
  output logic log_valid, // Log answer pulse
  output logic [DHM_TMR_W-1:0] log_time_left, // Cycles to next pass
  output logic log_bad_page, // Log page not supported
  output logic pass_active, // Off-line pass running
  output logic pass_save, // Saving data to the medium
  output logic pass_done, // Pass completed pulse
  output logic pass_aborted, // Pass aborted pulse
  output logic sense_pending, // Sense report pending
  output logic [7:0] sense_key, // Sense key
  output logic [7:0] sense_asc, // Additional sense code
  output logic [7:0] sense_ascq, // Additional qualifier
  output logic [7:0] failing_unit_field, // Failure type
  output logic nv_write, // Store report pulse
  output logic [7:0] nv_wdata, // Unit to store
  output logic cmd_hold // Delay command for monitor work
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_reg; // Two-stage reset release
  logic rst_n_sync; // Synchronised reset

  // Async assert, clocked release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sync_reg[1];

  // ----------------------------------------------------------------------
  // Attribute counters
  // ----------------------------------------------------------------------
  logic collect; // On-line collection allowed
  logic [NATTR-1:0] predict; // Per-attribute prediction
  logic [7:0] first_unit; // Lowest predicting attribute

  assign collect = !monitor_disable_bit;

  genvar gi;
  generate
    for (gi = 0; gi < NATTR; gi++) begin : g_attr
      dhm_attr #(.CNT_W(CNT_W)) u_attr (
        .sys_clk(sys_clk),
        .rst_n_sync(rst_n_sync),
        .enable(collect),
        .op_evt(op_evt[gi]),
        .err_evt(err_evt[gi]),
        .interval_len(interval_len),
        .err_thresh(err_thresh),
        .pred_thresh(pred_thresh),
        .predict(predict[gi]),
        .history()
      );
    end
  endgenerate

  // Lowest index predicting attribute, encoded as failure type
  function automatic logic [7:0] dhm_first(input logic [NATTR-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = NATTR - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'(i + 1);
      end
    end
    return r;
  endfunction
  assign first_unit = dhm_first(predict);

  // ----------------------------------------------------------------------
  // Hour timer and pass sequencer
  // ----------------------------------------------------------------------
  localparam logic [DHM_TMR_W-1:0] HOUR_LOAD = DHM_TMR_W'(HOUR_CYC - 1);
  localparam logic [15:0] MEAS_LAST = 16'(MEAS_CYC - 1);
  localparam logic [15:0] SAVE_LAST = 16'(SAVE_CYC - 1);

  logic [DHM_TMR_W-1:0] tmr_reg, tmr_next; // Time to next pass
  logic due_reg, due_next; // Pass due, waiting for idle
  dhm_state_t st_reg, st_next; // Pass state
  logic [15:0] step_reg, step_next; // Cycles within a phase
  logic done_next, abort_next; // Completion pulses
  logic offline_ok; // Off-line work permitted

  assign offline_ok = !monitor_disable_bit && !online_only_bit;

  // Next-state for timer, due flag and sequencer
  always_comb begin
    tmr_next = tmr_reg;
    due_next = due_reg;
    st_next = st_reg;
    step_next = step_reg;
    done_next = 1'b0;
    abort_next = 1'b0;
    // Free-running countdown, reload every hour
    if (tmr_reg == '0) begin
      tmr_next = HOUR_LOAD;
      due_next = offline_ok;
    end else begin
      tmr_next = tmr_reg - 1'b1;
    end
    if (!offline_ok) begin
      // Suspended: drop any pending or running pass
      due_next = 1'b0;
      abort_next = st_reg != DHM_IDLE;
      st_next = DHM_IDLE;
    end else if (rezero_force_command) begin
      // Forced pass starts now, whatever the host does
      tmr_next = HOUR_LOAD;
      due_next = 1'b0;
      st_next = DHM_MEAS;
      step_next = '0;
    end else begin
      unique case (st_reg)
        DHM_IDLE: begin
          if (due_reg && !host_busy) begin
            due_next = 1'b0;
            st_next = DHM_MEAS;
            step_next = '0;
          end
        end
        DHM_MEAS: begin
          if (host_busy) begin
            st_next = DHM_IDLE;
            abort_next = 1'b1;
          end else if (step_reg == MEAS_LAST) begin
            st_next = DHM_SAVE;
            step_next = '0;
          end else begin
            step_next = step_reg + 1'b1;
          end
        end
        DHM_SAVE: begin
          if (host_busy) begin
            st_next = DHM_IDLE;
            abort_next = 1'b1;
          end else if (step_reg == SAVE_LAST) begin
            st_next = DHM_IDLE;
            done_next = 1'b1;
          end else begin
            step_next = step_reg + 1'b1;
          end
        end
        default: begin
          st_next = DHM_IDLE;
        end
      endcase
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      tmr_reg <= HOUR_LOAD;
      due_reg <= 1'b0;
      st_reg <= DHM_IDLE;
      step_reg <= 16'h0000;
      pass_done <= 1'b0;
      pass_aborted <= 1'b0;
      pass_active <= 1'b0;
      pass_save <= 1'b0;
    end else begin
      tmr_reg <= tmr_next;
      due_reg <= due_next;
      st_reg <= st_next;
      step_reg <= step_next;
      pass_done <= done_next;
      pass_aborted <= abort_next;
      pass_active <= st_next != DHM_IDLE;
      pass_save <= st_next == DHM_SAVE;
    end
  end

  // ----------------------------------------------------------------------
  // Log sense answer
  // ----------------------------------------------------------------------
  // One-cycle answer: timer value, or flag for other pages
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      log_valid <= 1'b0;
      log_time_left <= '0;
      log_bad_page <= 1'b0;
    end else begin
      log_valid <= log_sense_req;
      log_bad_page <= log_sense_req && (log_sense_page != DHM_LOG_PAGE);
      if (log_sense_req && log_sense_page == DHM_LOG_PAGE) begin
        log_time_left <= tmr_reg;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Command delay limiter
  // ----------------------------------------------------------------------
  // Hold is capped so monitor work never delays a command past 75 ms
  logic [31:0] hold_cnt_reg, hold_cnt_next; // Cycles held so far
  logic hold_next; // Next hold level
  always_comb begin
    hold_next = 1'b0;
    hold_cnt_next = '0;
    if (collect && host_busy && pass_active && hold_cnt_reg < DELAY_CYC - 1) begin
      hold_next = 1'b1;
      hold_cnt_next = hold_cnt_reg + 1'b1;
    end else if (host_busy && pass_active) begin
      hold_cnt_next = hold_cnt_reg; // Saturate until idle
    end
  end

  // ----------------------------------------------------------------------
  // Predictive failure report
  // ----------------------------------------------------------------------
  logic pend_next; // Next pending level
  logic [7:0] unit_next; // Next failing unit
  logic nvw_next; // Next store pulse
  logic loaded_reg; // Stored report check done

  // Report new failure, or restore stored one after reset
  always_comb begin
    pend_next = sense_pending;
    unit_next = failing_unit_field;
    nvw_next = 1'b0;
    if (!loaded_reg && nv_valid) begin
      pend_next = 1'b1; // restored after power cycle
      unit_next = nv_unit;
    end else if (collect && exception_report_method == DHM_EXCEPTION_REPORT_METHOD_SENSE
                 && first_unit != 8'h00 && !sense_pending) begin
      pend_next = 1'b1;
      unit_next = first_unit;
      nvw_next = 1'b1;
    end else if (sense_ack) begin
      pend_next = 1'b0;
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      hold_cnt_reg <= '0;
      cmd_hold <= 1'b0;
      loaded_reg <= 1'b0;
      sense_pending <= 1'b0;
      failing_unit_field <= 8'h00;
      nv_write <= 1'b0;
      nv_wdata <= 8'h00;
      sense_key <= 8'h00;
      sense_asc <= 8'h00;
      sense_ascq <= 8'h00;
    end else begin
      hold_cnt_reg <= hold_cnt_next;
      cmd_hold <= hold_next;
      loaded_reg <= 1'b1;
      sense_pending <= pend_next;
      failing_unit_field <= unit_next;
      nv_write <= nvw_next;
      nv_wdata <= unit_next;
      sense_key <= pend_next ? DHM_SENSE_KEY : 8'h00;
      sense_asc <= pend_next ? DHM_SENSE_ASC : 8'h00;
      sense_ascq <= pend_next ? DHM_SENSE_ASCQ : 8'h00;
    end
  end

endmodule

// *** testbench/dhm_checker.sv ***
// Port-level assertion checker for the drive health monitor.
`timescale 1ns/1ns
module dhm_checker
  import dhm_pkg::*;
#(
  parameter longint unsigned HOUR_CYC = 200, // Cycles per hour
  parameter int unsigned DELAY_CYC = 20 // Longest command hold
) (
  input wire logic sys_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic monitor_disable_bit, // Suspend all
  input wire logic online_only_bit, // No off-line passes
  input wire logic host_busy, // Host activity
  input wire logic rezero_force_command, // Force pulse
  input wire logic log_sense_req, // Log request
  input wire logic [7:0] log_sense_page, // Log page
  input wire logic sense_ack, // Sense taken
  input wire logic log_valid, // Log answer
  input wire logic [DHM_TMR_W-1:0] log_time_left, // Time left
  input wire logic log_bad_page, // Unknown page
  input wire logic pass_active, // Pass running
  input wire logic pass_save, // Saving
  input wire logic pass_done, // Pass finished
  input wire logic pass_aborted, // Pass cut short
  input wire logic sense_pending, // Report waiting
  input wire logic [7:0] sense_key, // Key
  input wire logic [7:0] sense_asc, // Code
  input wire logic [7:0] sense_ascq, // Qualifier
  input wire logic [7:0] failing_unit_field, // Failure type
  input wire logic nv_write, // Store pulse
  input wire logic [7:0] nv_wdata, // Stored unit
  input wire logic cmd_hold // Command delayed
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Hold length counter
  // ----------------------------------------------------------------
  int unsigned hold_reg; // Cycles cmd_hold has stood
  int unsigned hold_next; // Next count
  // Restart whenever the hold drops
  always_comb begin
    hold_next = cmd_hold ? hold_reg + 1 : 0;
  end
  // Register the count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) hold_reg <= 0;
    else hold_reg <= hold_next;
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_log_ans;
    log_sense_req && log_sense_page == DHM_LOG_PAGE |=> log_valid && !log_bad_page;
  endproperty
  a_log_ans: assert property (p_log_ans) else $error("log answer missing");
  property p_log_time;
    log_valid |-> log_time_left < HOUR_CYC;
  endproperty
  a_log_time: assert property (p_log_time) else $error("time left too big");
  property p_dis;
    $rose(pass_active) |-> !$past(monitor_disable_bit);
  endproperty
  a_dis: assert property (p_dis) else $error("pass while disabled");
  property p_onl;
    $rose(pass_active) |-> !$past(online_only_bit);
  endproperty
  a_onl: assert property (p_onl) else $error("pass in on-line mode");
  property p_rez;
    rezero_force_command && !monitor_disable_bit && !online_only_bit && !pass_active
      |=> pass_active;
  endproperty
  a_rez: assert property (p_rez) else $error("rezero did not start pass");
  property p_abort;
    pass_active && host_busy |-> ##[0:2] (pass_aborted || pass_done);
  endproperty
  a_abort: assert property (p_abort) else $error("busy did not abort");
  property p_save_end;
    $fell(pass_save) |-> pass_done || pass_aborted;
  endproperty
  a_save_end: assert property (p_save_end) else $error("save ended silently");
  property p_sense;
    sense_pending |-> {sense_key, sense_asc, sense_ascq} == 24'h015D00
      && failing_unit_field != 8'h00;
  endproperty
  a_sense: assert property (p_sense) else $error("bad sense code");
  property p_pend_hold;
    sense_pending && !sense_ack |=> sense_pending;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("report dropped");
  property p_nv;
    nv_write |-> nv_wdata != 8'h00;
  endproperty
  a_nv: assert property (p_nv) else $error("empty stored unit");
  property p_delay;
    hold_reg <= DELAY_CYC;
  endproperty
  a_delay: assert property (p_delay) else $error("command held too long");

  // Main scenarios reached
  c_done: cover property (pass_done);
  c_abort: cover property (pass_aborted);
  c_sense: cover property ($rose(sense_pending));
endmodule

// *** testbench/dhm_host_model.sv ***
// Host initiator model issuing commands toward the monitor.
`timescale 1ns/1ns
module dhm_host_model (
  input wire logic sys_clk, // System clock
  output logic host_busy, // Interface activity
  output logic rezero_force_command, // Rezero pulse
  output logic log_sense_req, // Log sense pulse
  output logic [7:0] log_sense_page, // Requested page
  output logic sense_ack // Sense data taken
);
  // Idle host at time zero
  initial begin
    host_busy = 1'b0;
    rezero_force_command = 1'b0;
    log_sense_req = 1'b0;
    log_sense_page = 8'h00;
    sense_ack = 1'b0;
  end

  // ----------------------------------------------------------------
  // Command tasks, launched just after an edge
  // ----------------------------------------------------------------
  task automatic set_busy(input logic b);
    @(posedge sys_clk);
    #1 host_busy = b;
  endtask
  task automatic rezero();
    @(posedge sys_clk);
    #1 rezero_force_command = 1'b1;
    @(posedge sys_clk);
    #1 rezero_force_command = 1'b0;
  endtask
  task automatic log_query(input logic [7:0] pg);
    @(posedge sys_clk);
    #1 log_sense_req = 1'b1;
    log_sense_page = pg;
    @(posedge sys_clk);
    #1 log_sense_req = 1'b0;
    // Released page bus must not look still valid
    log_sense_page = ~pg;
  endtask
  // Slow hosts wait some cycles before taking sense data
  task automatic take_sense(input int wait_cyc);
    repeat (wait_cyc + 1) @(posedge sys_clk);
    #1 sense_ack = 1'b1;
    @(posedge sys_clk);
    #1 sense_ack = 1'b0;
  endtask
endmodule

// *** testbench/dhm_top_tb.sv ***
// Self-checking testbench for the drive health monitor top.
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
  $display("mismatch at %0t got %0h exp %0h", $time, a, b); end end
`define WAITF(c, n) begin int k; k = 0; while ((c) !== 1'b1 && k < n) begin \
  @(posedge sys_clk); #1; k++; end if ((c) !== 1'b1) begin fails++; give_verdict(); end end
module dhm_top_tb;
  import dhm_pkg::*;
  localparam longint unsigned HOUR = 200; // Shortened hour
  logic sys_clk = 1'b0; // Clock
  logic rst_n = 1'b0; // Reset
  logic monitor_disable_bit, online_only_bit, nv_valid; // Config levels
  logic [3:0] exception_report_method, op_evt, err_evt; // Method, events
  logic [15:0] interval_len, err_thresh, pred_thresh; // Thresholds
  logic [7:0] nv_unit, log_sense_page; // Stored unit, page
  logic host_busy, rezero_force_command, log_sense_req, sense_ack; // From host
  logic log_valid, log_bad_page, pass_active, pass_save, pass_done; // Status
  logic pass_aborted, sense_pending, nv_write, cmd_hold; // Status
  logic [DHM_TMR_W-1:0] log_time_left; // Time left
  logic [7:0] sense_key, sense_asc, sense_ascq, failing_unit_field, nv_wdata; // Report
  int fails = 0; // Mismatches
  int check_count = 0; // Comparisons
  int n; // Cycle tally
  int idx; // Attribute under test

  always #5 sys_clk = ~sys_clk;

  dhm_top #(.HOUR_CYC(HOUR), .DELAY_CYC(20), .MEAS_CYC(4), .SAVE_CYC(4)) dhm_top_inst (.*);
  dhm_host_model dhm_host_model_inst (.*);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_unit(input int i);
    return 8'(i + 1); // Failure type counts from one
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    `CHK(pass_active | sense_pending, 1'b0)
    #1 rst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // One operation, with or without an error, plus random background ops
  task automatic ev(input int i, input logic err);
    @(posedge sys_clk);
    #1 op_evt = 4'($urandom) | 4'(1 << i);
    err_evt = err ? 4'(1 << i) : 4'h0;
    @(posedge sys_clk);
    #1 op_evt = 4'h0;
    err_evt = 4'h0;
  endtask
  task automatic bad(input int i); // Errors pass threshold early
    ev(i, 1'b1);
    ev(i, 1'b1);
  endtask
  task automatic good(input int i); // Full clean interval
    repeat (4) ev(i, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {monitor_disable_bit, online_only_bit, nv_valid, nv_unit} = '0;
    {op_evt, err_evt} = '0;
    exception_report_method = 4'h1;
    interval_len = 16'h0004;
    err_thresh = 16'h0001;
    pred_thresh = 16'h0002;
    void'($urandom(32'hD2D33653));
    do_reset();
    dhm_host_model_inst.log_query(DHM_LOG_PAGE);
    `CHK(log_time_left inside {[HOUR - 12:HOUR - 1]}, 1'b1)
    dhm_host_model_inst.log_query(8'h10);
    `CHK(log_bad_page, 1'b1)
    repeat (100) @(posedge sys_clk);
    // Forced pass runs measure then save, timer restarts
    dhm_host_model_inst.rezero();
    `CHK(pass_active, 1'b1)
    n = 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1 n += pass_save;
    end
    `CHK(n, 4)
    `CHK(pass_active, 1'b0)
    dhm_host_model_inst.log_query(DHM_LOG_PAGE);
    `CHK(log_time_left inside {[HOUR - 30:HOUR - 1]}, 1'b1)
    // Busy host aborts a pass and holds off the hourly one
    dhm_host_model_inst.set_busy(1'b1);
    dhm_host_model_inst.rezero();
    `WAITF(pass_aborted, 4)
    n = 0;
    repeat (250) begin
      @(posedge sys_clk);
      #1 n += pass_active;
    end
    `CHK(n, 0)
    dhm_host_model_inst.set_busy(1'b0);
    `WAITF(pass_active, 4)
    repeat (20) @(posedge sys_clk);
    #1;
    // Disable, then on-line-only: a forced pass must not start
    for (int m = 0; m < 2; m++) begin
      {monitor_disable_bit, online_only_bit} = (m == 0) ? 2'b10 : 2'b01;
      dhm_host_model_inst.rezero();
      n = 0;
      repeat (10) begin
        @(posedge sys_clk);
        #1 n += pass_active;
      end
      `CHK(n, 0)
    end
    online_only_bit = 1'b0;
    monitor_disable_bit = 1'b1;
    repeat (3) bad(0);
    `CHK(sense_pending, 1'b0)
    monitor_disable_bit = 1'b0;
    // Other report method, then prediction turned off: no report may follow
    for (int m = 0; m < 2; m++) begin
      exception_report_method = (m == 0) ? 4'($urandom_range(15, 2)) : 4'h1;
      pred_thresh = (m == 0) ? 16'h0002 : 16'h0000;
      do_reset();
      idx = $urandom_range(3);
      repeat (2) bad(idx);
      repeat (5) @(posedge sys_clk);
      #1;
      `CHK(sense_pending, 1'b0)
    end
    exception_report_method = 4'h1;
    pred_thresh = 16'h0002;
    do_reset();
    // Random attribute: bad, good, bad stays below threshold; one more predicts
    for (int r = 0; r < 3; r++) begin
      idx = $urandom_range(3);
      bad(idx);
      good(idx);
      bad(idx);
      repeat (5) @(posedge sys_clk);
      #1;
      `CHK(sense_pending, 1'b0)
      bad(idx);
      `WAITF(sense_pending, 10)
      `CHK(failing_unit_field, exp_unit(idx))
      `CHK({sense_key, sense_asc, sense_ascq}, 24'h015D00)
      nv_valid = 1'b1;
      nv_unit = exp_unit(idx);
      do_reset();
      `WAITF(sense_pending, 10)
      `CHK(failing_unit_field, exp_unit(idx))
      dhm_host_model_inst.take_sense(r * 4);
      `WAITF(!sense_pending, 10)
      nv_valid = 1'b0;
      do_reset();
    end
    give_verdict();
  end
endmodule
bind dhm_top dhm_checker #(.HOUR_CYC(HOUR_CYC), .DELAY_CYC(DELAY_CYC)) dhm_checker_inst (.*);
